/* File: hdl/sdf_pkg.sv */
// constants and types shared by the step driver fault supervisor
package sdf_pkg;
    localparam int CLK_FREQ_HZ = 25000000;
    localparam real ENA_DELAY_US = 1.808449;
    // least time, rounded up to whole cycles
    localparam int ENA_DELAY_CYC = int'($ceil(ENA_DELAY_US * CLK_FREQ_HZ / 1.0e6));
    localparam real RST_PULSE_US = 10.0;
    localparam int RST_PULSE_CYC = int'($ceil(RST_PULSE_US * CLK_FREQ_HZ / 1.0e6));
    localparam int STEP_LOW_CYC = 4;
    localparam int STEP_SETUP_CYC = 2;
    localparam logic [7:0] STATUS_OK_CHAR = 8'h30;
    localparam logic [7:0] STATUS_FAULT_CHAR = 8'h67;

    typedef enum logic [2:0] {
        SDF_IDLE = 3'b000,
        SDF_POWERUP = 3'b001,
        SDF_SETUP = 3'b010,
        SDF_PULSE = 3'b011,
        SDF_RUN = 3'b100
    } sdf_state_t;
endpackage : sdf_pkg

/* File: hdl/sdf_step_driver_fault_supervisor.sv */
// per-axis step, direction, enable and shared fault/reset line supervisor
// Overview of operation
// - assert motor enable, wait power-up delay before first step of a motion
// - pending next move skips delay and keeps motor enabled between motions
// - drive active-low step, direction, active-high enable and shared fault/reset line
// - host configures line use and resets amplifier after power-up reset
// - sample fault line while moving and fault checking is enabled
// - on fault pulse amplifier reset and stop all motion
// - fault-check-on command starts monitoring the fault line
// - fault-check-off command stops monitoring and ignores the line
// - driver reset command pulses reset on the shared line
// - fault query reports line: 1 healthy, 0 fault
// - motor-off command forces motor off until driver reset command
// - fault status character held until driver reset command clears it
`timescale 1ns/100ps
module sdf_step_driver_fault_supervisor
    import sdf_pkg::*;
#(
    parameter int ENA_DELAY = ENA_DELAY_CYC,
    parameter int RST_PULSE = RST_PULSE_CYC,
    parameter int STEP_LOW = STEP_LOW_CYC,
    parameter int STEP_SETUP = STEP_SETUP_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic stepReq,
    input wire logic stepDir,
    input wire logic moveActive,
    input wire logic movePending,
    input wire logic faultCheckOnCmd,
    input wire logic faultCheckOffCmd,
    input wire logic driverResetCmd,
    input wire logic faultQueryCmd,
    input wire logic motorOffCmd,
    input wire logic faultInResetOutIn,
    output logic faultInResetOutOut,
    output logic faultInResetOutOe,
    output logic stepOutN,
    output logic dirOut,
    output logic motorEnable,
    output logic stepReady,
    output logic stepDone,
    output logic motionAbort,
    output logic faultCheckOn,
    output logic queryValid,
    output logic queryBit,
    output logic [7:0] statusChar,
    output logic motorLocked
);
    localparam int CW = 16;

    // counts the counters cannot hold are refused at elaboration
    if (ENA_DELAY < 1 || RST_PULSE < 1 || STEP_LOW < 1 || STEP_SETUP < 1
        || ENA_DELAY >= 2**CW || RST_PULSE >= 2**CW
        || STEP_LOW >= 2**CW || STEP_SETUP >= 2**CW) begin : g_bad_timing
        $error("sdf: timing parameter out of range");
    end

    function automatic logic [CW-1:0] cycCnt(input int n);
        cycCnt = CW'(n - 1);
    endfunction : cycCnt

    sdf_state_t state_ff;
    logic [CW-1:0] cnt_ff;
    logic faultSync1_ff, faultSync2_ff;
    logic checkOn_ff, faultLatched_ff, lock_ff, enable_ff;
    logic [CW-1:0] rstCnt_ff;
    logic rstActive_ff, dir_ff, stepN_ff, done_ff, abort_ff;
    logic qValid_ff, qBit_ff;
    logic faultSeen;
    logic [1:0] rstTail_ff;

    // line is ours while resetting and the synchroniser lags it by two cycles;
    // a real fault right after a pulse is seen two cycles late
    assign faultSeen = checkOn_ff && moveActive && !faultSync2_ff && !rstActive_ff
        && (rstTail_ff == 2'h0);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faultSync1_ff <= 1'b1;
            faultSync2_ff <= 1'b1;
        end else begin
            faultSync1_ff <= faultInResetOutIn;
            faultSync2_ff <= faultSync1_ff;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            checkOn_ff <= 1'b0;
        end else if (faultCheckOnCmd) begin
            checkOn_ff <= 1'b1;
        end else if (faultCheckOffCmd) begin
            checkOn_ff <= 1'b0;
        end
    end

    // set wins over clear when fault and reset command meet
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            faultLatched_ff <= 1'b0;
        end else if (faultSeen) begin
            faultLatched_ff <= 1'b1;
        end else if (driverResetCmd) begin
            faultLatched_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lock_ff <= 1'b0;
        end else if (motorOffCmd) begin
            lock_ff <= 1'b1;
        end else if (driverResetCmd) begin
            lock_ff <= 1'b0;
        end
    end

    // reset pulse from a command or an automatic fault reaction
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstActive_ff <= 1'b0;
            rstCnt_ff <= '0;
        end else if (driverResetCmd || faultSeen) begin
            rstActive_ff <= 1'b1;
            rstCnt_ff <= cycCnt(RST_PULSE);
        end else if (rstActive_ff) begin
            if (rstCnt_ff == '0) begin
                rstActive_ff <= 1'b0;
            end else begin
                rstCnt_ff <= rstCnt_ff - 1'b1;
            end
        end
    end

    // without this tail the stale low would trip a phantom fault after each pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstTail_ff <= 2'h0;
        end else begin
            rstTail_ff <= {rstTail_ff[0], rstActive_ff};
        end
    end

    // drive low only while resetting; released line is pulled up outside
    assign faultInResetOutOut = 1'b0;
    assign faultInResetOutOe = rstActive_ff;

    logic blocked;
    assign blocked = lock_ff || faultLatched_ff || faultSeen;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SDF_IDLE;
            cnt_ff <= '0;
            enable_ff <= 1'b0;
            dir_ff <= 1'b0;
            stepN_ff <= 1'b1;
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
            if (blocked) begin
                abort_ff <= (state_ff != SDF_IDLE) || faultSeen;
                state_ff <= SDF_IDLE;
                enable_ff <= 1'b0;
                stepN_ff <= 1'b1;
            end else begin
                unique case (state_ff)
                    SDF_IDLE: begin
                        if (stepReq) begin
                            dir_ff <= stepDir;
                            enable_ff <= 1'b1;
                            cnt_ff <= cycCnt(ENA_DELAY);
                            state_ff <= SDF_POWERUP;
                        end
                    end
                    SDF_POWERUP: begin
                        if (cnt_ff == '0) begin
                            cnt_ff <= cycCnt(STEP_SETUP);
                            state_ff <= SDF_SETUP;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    SDF_SETUP: begin
                        if (cnt_ff == '0) begin
                            stepN_ff <= 1'b0;
                            cnt_ff <= cycCnt(STEP_LOW);
                            state_ff <= SDF_PULSE;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    SDF_PULSE: begin
                        if (cnt_ff == '0) begin
                            stepN_ff <= 1'b1;
                            done_ff <= 1'b1;
                            state_ff <= SDF_RUN;
                        end else begin
                            cnt_ff <= cnt_ff - 1'b1;
                        end
                    end
                    SDF_RUN: begin
                        if (stepReq) begin
                            dir_ff <= stepDir;
                            cnt_ff <= cycCnt(STEP_SETUP);
                            state_ff <= SDF_SETUP;
                        end else if (!moveActive && !movePending) begin
                            enable_ff <= 1'b0;
                            state_ff <= SDF_IDLE;
                        end
                        // pending move keeps enable and skips the delay
                    end
                    default: begin
                        state_ff <= SDF_IDLE;
                        enable_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            qValid_ff <= 1'b0;
            qBit_ff <= 1'b1;
        end else begin
            qValid_ff <= faultQueryCmd;
            if (faultQueryCmd) begin
                qBit_ff <= faultSync2_ff;
            end
        end
    end

    assign stepOutN = stepN_ff;
    assign dirOut = dir_ff;
    assign motorEnable = enable_ff;
    assign stepReady = (state_ff == SDF_IDLE || state_ff == SDF_RUN) && !blocked;
    assign stepDone = done_ff;
    assign motionAbort = abort_ff;
    assign faultCheckOn = checkOn_ff;
    assign queryValid = qValid_ff;
    assign queryBit = qBit_ff;
    assign statusChar = faultLatched_ff ? STATUS_FAULT_CHAR : STATUS_OK_CHAR;
    assign motorLocked = lock_ff;

    // repetition follows the default low width; only an abort may cut it
    a_step_width: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(stepOutN) |-> (!stepOutN [*4])
        or (##[1:3] (stepOutN && motionAbort)))
        else $error("step low too short");

    a_dir_stable: assert property (@(posedge core_clk) disable iff (!resetn)
        !stepOutN |-> $stable(dirOut))
        else $error("direction moved during step");

    sequence s_start;
        state_ff == SDF_IDLE && stepReq && !blocked;
    endsequence
    a_powerup_wait: assert property (@(posedge core_clk) disable iff (!resetn)
        s_start ##1 motorEnable |-> stepOutN [*4])
        else $error("step before power-up delay");

    a_keep_enable: assert property (@(posedge core_clk) disable iff (!resetn)
        state_ff == SDF_RUN && movePending && !blocked |=> motorEnable)
        else $error("enable dropped with move pending");

    a_fault_stop: assert property (@(posedge core_clk) disable iff (!resetn)
        faultSeen |=> !motorEnable && faultInResetOutOe && statusChar == STATUS_FAULT_CHAR)
        else $error("fault not handled");

    a_check_off: assert property (@(posedge core_clk) disable iff (!resetn)
        !faultCheckOn && !driverResetCmd
        |=> !$rose(faultInResetOutOe) && $stable(statusChar))
        else $error("fault seen while checking off");

    a_reset_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        driverResetCmd |=> faultInResetOutOe ##[1:300] !faultInResetOutOe)
        else $error("reset pulse missing or endless");

    a_query_value: assert property (@(posedge core_clk) disable iff (!resetn)
        faultQueryCmd |=> queryValid && queryBit == $past(faultSync2_ff))
        else $error("query answer wrong");

    a_motor_off: assert property (@(posedge core_clk) disable iff (!resetn)
        motorLocked && !driverResetCmd |=> !motorEnable && motorLocked)
        else $error("motor ran while forced off");

    a_line_drive: assert property (@(posedge core_clk) disable iff (!resetn)
        faultInResetOutOe |-> !faultInResetOutOut)
        else $error("shared line driven high");

    a_drive_cause: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(faultInResetOutOe) |-> $past(driverResetCmd) || $past(faultSeen))
        else $error("shared line driven without cause");

    // cycles since enable came up, saturating, for the power-up check
    logic [CW-1:0] enaAge_ff;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enaAge_ff <= '0;
        end else if (!enable_ff) begin
            enaAge_ff <= '0;
        end else if (enaAge_ff != '1) begin
            enaAge_ff <= enaAge_ff + 1'b1;
        end
    end

    a_delay_count: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(stepOutN) |-> enaAge_ff >= CW'(ENA_DELAY))
        else $error("step inside power-up delay");
endmodule : sdf_step_driver_fault_supervisor

/* File: tb/sdf_amp_model.sv */
// behavioural power amplifier on the far side of the shared fault/reset line
`timescale 1ns/100ps
module sdf_amp_model (
    input wire logic core_clk,
    input wire logic faultInject,
    input wire logic faultInResetOutOut,
    input wire logic faultInResetOutOe,
    output logic lineLevel,
    output logic ampFault
);
    logic fault_ff = 1'b0;
    logic pulledLow;
    assign pulledLow = faultInResetOutOe && !faultInResetOutOut;
    // fault stays latched until the controller pulls the line low
    always_ff @(posedge core_clk) begin
        if (pulledLow) begin
            fault_ff <= 1'b0;
        end else if (faultInject) begin
            fault_ff <= 1'b1;
        end
    end
    // pulled up, so a released line reads healthy
    assign lineLevel = !fault_ff && !pulledLow;
    assign ampFault = fault_ff;
endmodule : sdf_amp_model

/* File: tb/tb_step_driver_fault_supervisor.sv */
// self-checking bench for the step driver fault supervisor
`timescale 1ns/100ps
module tb_step_driver_fault_supervisor;
    import sdf_pkg::*;
    localparam int ENA = 6;
    localparam int RST = 4;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic stepReq = 1'b0;
    logic stepDir = 1'b0;
    logic moveActive = 1'b0;
    logic movePending = 1'b0;
    logic [4:0] cmd = 5'h00; // off lock, query, amp reset, check off, check on
    logic inject = 1'b0;
    logic lineLevel, ampFault, rOut, rOe, stepN, dirOut, motorEnable, stepReady, stepDone;
    logic abort, checkOn, queryValid, queryBit, motorLocked;
    logic [7:0] statusChar;
    int errorCnt = 0;
    int samplesChecked = 0;
    int cycles = 0;
    int lead;
    int n;
    sdf_step_driver_fault_supervisor #(.ENA_DELAY(ENA), .RST_PULSE(RST)) DUT (
        .core_clk(core_clk), .resetn(resetn), .stepReq(stepReq), .stepDir(stepDir),
        .moveActive(moveActive), .movePending(movePending), .faultCheckOnCmd(cmd[0]),
        .faultCheckOffCmd(cmd[1]), .driverResetCmd(cmd[2]), .faultQueryCmd(cmd[3]),
        .motorOffCmd(cmd[4]), .faultInResetOutIn(lineLevel), .faultInResetOutOut(rOut),
        .faultInResetOutOe(rOe), .stepOutN(stepN), .dirOut(dirOut),
        .motorEnable(motorEnable), .stepReady(stepReady), .stepDone(stepDone),
        .motionAbort(abort), .faultCheckOn(checkOn), .queryValid(queryValid),
        .queryBit(queryBit), .statusChar(statusChar), .motorLocked(motorLocked));
    sdf_amp_model amp (.core_clk(core_clk), .faultInject(inject), .faultInResetOutOut(rOut),
        .faultInResetOutOe(rOe), .lineLevel(lineLevel), .ampFault(ampFault));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic reportAndStop();
        if (errorCnt == 0 && samplesChecked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : reportAndStop
    // a hung handshake ends the run here instead of running forever
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            reportAndStop();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic send(input logic [4:0] v);
        @(posedge core_clk);
        cmd <= v;
        @(posedge core_clk);
        cmd <= 5'h00;
        #1;
    endtask : send
    task automatic pulseFault();
        @(posedge core_clk);
        inject <= 1'b1;
        @(posedge core_clk);
        inject <= 1'b0;
        #1;
    endtask : pulseFault
    // amp reset command: line driven low for a counted pulse
    task automatic ampReset(input logic [4:0] v);
        send(v);
        n = 0;
        while (rOe !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        n = 0;
        while (rOe === 1'b1 && n < 60) begin
            chk("resetDriveLevel", {7'h00, rOut}, 8'h00);
            tick(1);
            n++;
        end
        chk("resetPulseLen", n[7:0], 8'(RST));
    endtask : ampReset
    task automatic doStep(input logic d, output int ld);
        chk("stepReady", {7'h00, stepReady}, 8'h01);
        @(posedge core_clk);
        stepReq <= 1'b1;
        stepDir <= d;
        moveActive <= 1'b1;
        movePending <= 1'b0;
        @(posedge core_clk);
        stepReq <= 1'b0;
        #1;
        ld = 1;
        while (stepN !== 1'b0 && ld < 200) begin
            tick(1);
            ld++;
        end
        n = 0;
        while (stepN === 1'b0 && n < 50) begin
            chk("dirOut", {7'h00, dirOut}, {7'h00, d});
            chk("enableInStep", {7'h00, motorEnable}, 8'h01);
            tick(1);
            n++;
        end
        chk("stepLowWidth", n[7:0], 8'(STEP_LOW_CYC));
        n = 0;
        while (stepDone !== 1'b1 && n < 3) begin
            tick(1);
            n++;
        end
        chk("stepDone", {7'h00, stepDone}, 8'h01);
    endtask : doStep
    task automatic testSteps();
        doStep(1'b1, lead);
        chk("powerupWait", 8'(lead >= ENA + STEP_SETUP_CYC), 8'h01);
        @(posedge core_clk);
        moveActive <= 1'b0;
        movePending <= 1'b1;
        tick(3);
        chk("enableKept", {7'h00, motorEnable}, 8'h01);
        doStep(1'b0, lead);
        chk("delaySkipped", 8'(lead < ENA), 8'h01);
        @(posedge core_clk);
        moveActive <= 1'b0;
        tick(4);
        chk("enableDropped", {7'h00, motorEnable}, 8'h00);
    endtask : testSteps
    task automatic testQuery();
        send(5'h08);
        chk("queryOk", {6'h00, queryValid, queryBit}, 8'h03);
        pulseFault();
        tick(4);
        send(5'h08);
        chk("queryFault", {6'h00, queryValid, queryBit}, 8'h02);
        ampReset(5'h04);
        chk("ampCleared", {7'h00, ampFault}, 8'h00);
    endtask : testQuery
    task automatic testFault();
        @(posedge core_clk);
        stepReq <= 1'b1;
        moveActive <= 1'b1;
        @(posedge core_clk);
        stepReq <= 1'b0;
        inject <= 1'b1;
        @(posedge core_clk);
        inject <= 1'b0;
        #1;
        n = 0;
        while (abort !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        chk("abort", {7'h00, abort}, 8'h01);
        tick(1);
        chk("faultStop", {6'h00, motorEnable, rOe}, 8'h01);
        tick(RST + 4);
        chk("statusHeld", statusChar, STATUS_FAULT_CHAR);
        @(posedge core_clk);
        moveActive <= 1'b0;
        ampReset(5'h04);
        chk("statusCleared", statusChar, STATUS_OK_CHAR);
    endtask : testFault
    task automatic testCheckOff();
        send(5'h02);
        chk("checkOff", {7'h00, checkOn}, 8'h00);
        @(posedge core_clk);
        moveActive <= 1'b1;
        pulseFault();
        lead = 0;
        repeat (8) begin
            tick(1);
            lead = lead | int'(abort);
        end
        chk("faultIgnored", {7'h00, lead[0]}, 8'h00);
        @(posedge core_clk);
        moveActive <= 1'b0;
        ampReset(5'h05);
        chk("checkOn", {7'h00, checkOn}, 8'h01);
    endtask : testCheckOff
    task automatic testMotorOff();
        send(5'h10);
        chk("locked", {5'h00, motorLocked, motorEnable, stepReady}, 8'h04);
        @(posedge core_clk);
        stepReq <= 1'b1;
        @(posedge core_clk);
        stepReq <= 1'b0;
        tick(4);
        chk("lockedStep", {7'h00, motorEnable}, 8'h00);
        ampReset(5'h04);
        chk("unlocked", {6'h00, motorLocked, stepReady}, 8'h01);
    endtask : testMotorOff
    initial begin
        tick(20);
        chk("resetOut", {3'h0, stepN, motorEnable, rOe, checkOn, queryBit}, 8'h11);
        chk("resetStatus", statusChar, STATUS_OK_CHAR);
        @(posedge core_clk);
        resetn <= 1'b1;
        tick(2);
        // host's first command after reset, nothing precedes it
        ampReset(5'h05); // configuring command
        chk("configCheckOn", {7'h00, checkOn}, 8'h01);
        testSteps();
        testQuery();
        testFault();
        testCheckOff();
        testMotorOff();
        reportAndStop();
    end
endmodule : tb_step_driver_fault_supervisor
